// *** core_swap_timing_trim_regs.sv ***
// Contract
// RQ1 - Three 8-bit termination trims reset from fuses, readable and writable.
// RQ2 - Software changes overlap delay only while calibration is disabled.
// RQ3 - Both cores sample together for 4 + 2*overlap converter cycles.
// RQ4 - Overlap field is bits 4:0, range 0 to 31, reset eight.
// RQ5 - Slow converter clock may use overlap seven; reset suits all.
// RQ6 - Steering delay added to select only during background swaps.
// RQ7 - Software tunes steering delay to switch inside valid overlap.
// RQ8 - Steering field is bits 4:0, range 0 to 31, reset seven.
// RQ9 - Software writes zero to reserved upper bits.
// RQ10 - Dither control bit 0 enables converter dither.
// RQ11 - Swap latches both delays at start, holds them until done.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module core_swap_timing_trim_regs
    import swap_trim_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Fuse trims, stable from reset release
    input  wire logic [7:0]  fuse_trim_b,
    input  wire logic [7:0]  fuse_trim_c,
    input  wire logic [7:0]  fuse_trim_d,
    // Swap request from the background calibration logic
    input  wire logic        swap_start,
    // Analogue side controls
    output logic      [7:0]  input_b_termination_trim,
    output logic      [7:0]  input_c_termination_trim,
    output logic      [7:0]  input_d_termination_trim,
    output dither_cfg_t      dither_cfg,
    output logic             overlap_active,
    output logic             steer_select,
    output logic             swap_busy
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]  trim_b_ff;
    logic [7:0]  trim_c_ff;
    logic [7:0]  trim_d_ff;
    logic [4:0]  overlap_ff;
    logic [4:0]  steer_ff;
    logic [2:0]  dither_ff;
    logic        fuse_load_ff;
    logic        ack_ff;
    logic        err_ff;
    logic [31:0] rdata_ff;
    logic [7:0]  swap_cnt_ff;
    logic        swap_done;
    swap_cfg_t   cur_cfg;

    // Word index from byte address
    function automatic logic [8:0] word_index(input logic [11:0] adr);
        word_index = adr[10:2];
    endfunction : word_index

    function automatic logic mapped(input logic [8:0] idx);
        mapped = (idx == IDX_TRIM_B) || (idx == IDX_TRIM_C)
              || (idx == IDX_TRIM_D) || (idx == IDX_OVERLAP)
              || (idx == IDX_STEER)  || (idx == IDX_DITHER)
              || (idx == IDX_SWAP_STATUS);
    endfunction : mapped

    logic [8:0] idx;
    logic       req;
    logic       wr_lo;
    assign idx   = word_index(wb_adr_i);
    // One request per cycle; ack cycle suppresses a repeat take
    assign req   = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;
    assign wr_lo = req && wb_we_i && wb_sel_i[0] && mapped(idx)
                   && (wb_adr_i[11] == 1'b0) && (wb_adr_i[1:0] == 2'b00);

    // ------------------------------------------------------------
    // Bus answer: ack or err one cycle after the request is seen
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ack_ff <= 1'b0;
            err_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= req && mapped(idx) && !wb_adr_i[11];
            err_ff <= req && !(mapped(idx) && !wb_adr_i[11]);
        end
    end

    // ------------------------------------------------------------
    // Trim registers
    // ------------------------------------------------------------
    // Fuse values cannot be taken under async reset, so the first
    // clock after release copies them in.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            fuse_load_ff <= 1'b1;
        else
            fuse_load_ff <= 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            trim_b_ff <= 8'h00;
            trim_c_ff <= 8'h00;
            trim_d_ff <= 8'h00;
        end
        else if (fuse_load_ff)
        begin
            trim_b_ff <= fuse_trim_b;                               // RQ1
            trim_c_ff <= fuse_trim_c;                               // RQ1
            trim_d_ff <= fuse_trim_d;                               // RQ1
        end
        else if (wr_lo)
        begin
            if (idx == IDX_TRIM_B)
                trim_b_ff <= wb_dat_i[7:0];                         // RQ1
            if (idx == IDX_TRIM_C)
                trim_c_ff <= wb_dat_i[7:0];                         // RQ1
            if (idx == IDX_TRIM_D)
                trim_d_ff <= wb_dat_i[7:0];                         // RQ1
        end
    end

    // ------------------------------------------------------------
    // Swap delays and dither control
    // ------------------------------------------------------------
    // Reserved bits are not stored; they read back as zero.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            overlap_ff <= OVERLAP_RST;                              // RQ4
            steer_ff   <= STEER_RST;                                // RQ8
            dither_ff  <= DITHER_RST;
        end
        else if (wr_lo)
        begin
            if (idx == IDX_OVERLAP)
                overlap_ff <= wb_dat_i[DLY_W-1:0];                  // RQ4
            if (idx == IDX_STEER)
                steer_ff <= wb_dat_i[DLY_W-1:0];                    // RQ8
            if (idx == IDX_DITHER)
                dither_ff <= wb_dat_i[2:0];
        end
    end

    // ------------------------------------------------------------
    // Completed swap counter, visible in the status word
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            swap_cnt_ff <= 8'h00;
        else if (swap_done)
            swap_cnt_ff <= swap_cnt_ff + 8'h01;
    end

    // ------------------------------------------------------------
    // Read data, registered with the ack
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_ff <= 32'h0000_0000;
        else if (req && !wb_we_i)
        begin
            // Upper half of the map is refused; index 0 falls to default
            unique case (wb_adr_i[11] ? 9'h000 : idx)
                IDX_TRIM_B:      rdata_ff <= {24'h0, trim_b_ff};
                IDX_TRIM_C:      rdata_ff <= {24'h0, trim_c_ff};
                IDX_TRIM_D:      rdata_ff <= {24'h0, trim_d_ff};
                IDX_OVERLAP:     rdata_ff <= {27'h0, overlap_ff};
                IDX_STEER:       rdata_ff <= {27'h0, steer_ff};
                IDX_DITHER:      rdata_ff <= {29'h0, dither_ff};
                IDX_SWAP_STATUS: rdata_ff <= {23'h0, swap_cnt_ff,
                                              swap_busy};
                default:         rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Swap engine
    // ------------------------------------------------------------
    // Software is expected to change overlap only with calibration
    // off; the engine still latches values so a late write is safe.
    assign cur_cfg.overlap = overlap_ff;                            // RQ2
    assign cur_cfg.steer   = steer_ff;

    swap_sequencer u_seq
    (
        .clk            (clk),
        .rst            (rst),
        .swap_start     (swap_start),
        .cfg            (cur_cfg),
        .overlap_active (overlap_active),
        .steer_select   (steer_select),
        .swap_busy      (swap_busy),
        .swap_done      (swap_done)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign input_b_termination_trim = trim_b_ff;
    assign input_c_termination_trim = trim_c_ff;
    assign input_d_termination_trim = trim_d_ff;
    assign dither_cfg.dither_enable           = dither_ff[DITH_EN_BIT];  // RQ10
    assign dither_cfg.dither_amplitude_select = dither_ff[DITH_AMP_BIT];
    assign dither_cfg.dither_rounding_choice  = dither_ff[DITH_RND_BIT];
    assign wb_dat_o = rdata_ff;
    assign wb_ack_o = ack_ff;
    assign wb_err_o = err_ff;

endmodule : core_swap_timing_trim_regs

// *** core_swap_timing_trim_regs_bench.sv ***
`timescale 1ns/1ps
module core_swap_timing_trim_regs_bench
    import swap_trim_pkg::*;
;
    logic        clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, oc, bc;
    logic        wb_ack_o, wb_err_o, e, swap_start = 0, sel0;
    logic [7:0]  input_b_termination_trim, input_c_termination_trim;
    logic [7:0]  input_d_termination_trim;
    logic [7:0]  fuse_trim_b = 8'ha5, fuse_trim_c = 8'h3c, fuse_trim_d = 8'hf0;
    dither_cfg_t dither_cfg;
    logic        overlap_active, steer_select, swap_busy;
    int          failures = 0, checked = 0, cycles = 0;

    core_swap_timing_trim_regs core_swap_timing_trim_regs_i (.clk, .rst,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .fuse_trim_b, .fuse_trim_c,
        .fuse_trim_d, .swap_start, .input_b_termination_trim,
        .input_c_termination_trim, .input_d_termination_trim, .dither_cfg,
        .overlap_active, .steer_select, .swap_busy);

    // --------
    // Clock, timeout, swap cycle counters
    // --------
    always #12.5 clk = ~clk;

    // Cut a hang short well past the expected run
    always @(posedge clk)
    begin
        oc <= swap_start ? 32'h0 : oc + overlap_active;
        bc <= swap_start ? 32'h0 : bc + swap_busy;
        cycles++;
        if (cycles > 5000)
        begin
            failures++;
            final_report();
        end
    end

    // --------
    // Tasks
    // --------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // Classic cycle: hold until ack or err is sampled, then idle one cycle
    task automatic wb(input logic w, input logic [8:0] i, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= {1'b0, i, 2'b00};
        wb_dat_i <= d;
        // No local limit: only the bench timeout ends a wait
        do
        begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic test_regs();
        logic [8:0] idx [3] = '{IDX_TRIM_B, IDX_TRIM_C, IDX_TRIM_D};
        logic [7:0] fz [3] = '{8'ha5, 8'h3c, 8'hf0};
        for (int k = 0; k < 3; k++)
        begin
            wb(0, idx[k], 0); check(q, {24'h0, fz[k]});
            wb(1, idx[k], 32'h5a + k);
            wb(0, idx[k], 0); check(q, 32'h5a + k);
        end
        check(input_b_termination_trim, 8'h5a);
        check(input_c_termination_trim, 8'h5b);
        check(input_d_termination_trim, 8'h5c);
        wb(0, IDX_OVERLAP, 0); check(q, 32'h08);
        wb(0, IDX_STEER, 0); check(q, 32'h07);
        wb(1, IDX_OVERLAP, 32'h1f); wb(0, IDX_OVERLAP, 0);
        check(q, 32'h1f);
        // Struct packs enable as its top bit
        wb(1, IDX_DITHER, 32'h01); check(dither_cfg, 3'b100);
        wb(1, IDX_DITHER, 32'h07); wb(0, IDX_DITHER, 0);
        check(q, 32'h07);
        wb(0, 9'h0a1, 0);
        check(e, 1'b1);
        check(q, 32'h0);
        $display("register test done");
    endtask : test_regs

    // Steering changed mid-swap must not alter the running swap
    task automatic test_swap(input int ov, input int st, input int nst,
                             input int nsw);
        int n;
        sel0 = steer_select;
        wb(1, IDX_OVERLAP, ov);
        wb(1, IDX_STEER, st);
        swap_start <= 1'b1;
        @(posedge clk);
        swap_start <= 1'b0;
        wb(1, IDX_STEER, nst);
        for (n = 0; n < 200 && swap_busy !== 1'b0; n++) @(posedge clk);
        @(posedge clk);
        check(oc, 4 + 2 * ov);
        check(bc, 5 + 2 * ov + st);
        check(steer_select, !sel0);
        // Status word: completed count above the idle busy bit
        wb(0, IDX_SWAP_STATUS, 0);
        check(q, 2 * nsw);
        $display("swap test done");
    endtask : test_swap

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    // --------
    // Main sequence
    // --------
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        test_regs();
        test_swap(0, 0, 9, 1);
        test_swap(31, 31, 2, 2);
        test_swap(7, 3, 0, 3);
        final_report();
    end
endmodule : core_swap_timing_trim_regs_bench

// *** core_swap_timing_trim_regs_chk.sv ***
`timescale 1ns/1ps
module core_swap_timing_trim_regs_chk
    import swap_trim_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        swap_start,
    input wire logic        overlap_active,
    input wire logic        steer_select,
    input wire logic        swap_busy
);
    logic [4:0] ov_ff, st_ff, ov_lat_ff, st_lat_ff;
    logic [7:0] ocnt_ff, bcnt_ff;
    logic       wr_hit;
    logic [8:0] idx;

    // --------
    // Shadow of the delay fields
    // --------
    assign idx = wb_adr_i[10:2];
    assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
                    & (wb_adr_i[1:0] == 2'h0) & !wb_adr_i[11];

    // Shadow trails the design by one edge; harmless, no swap starts then
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ov_ff <= OVERLAP_RST;
            st_ff <= STEER_RST;
        end
        else if (wr_hit && idx == IDX_OVERLAP)
            ov_ff <= wb_dat_i[4:0];
        else if (wr_hit && idx == IDX_STEER)
            st_ff <= wb_dat_i[4:0];
    end

    // Latch at swap start, count overlap and busy cycles
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ov_lat_ff <= 5'h00;
            st_lat_ff <= 5'h00;
            ocnt_ff   <= 8'h00;
            bcnt_ff   <= 8'h00;
        end
        else
        begin
            if (swap_start && !swap_busy)
            begin
                ov_lat_ff <= ov_ff;
                st_lat_ff <= st_ff;
            end
            ocnt_ff <= overlap_active ? ocnt_ff + 8'h01 : 8'h00;
            bcnt_ff <= swap_busy ? bcnt_ff + 8'h01 : 8'h00;
        end
    end

    // --------
    // Properties
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    chk_ack_cause: assert property (
        $rose(wb_ack_o) |-> $past(wb_cyc_i & wb_stb_i))
        else $error("ack without request");
    chk_overlap_min: assert property (
        $rose(overlap_active) |-> overlap_active [*4])
        else $error("overlap shorter than four");
    chk_overlap_len: assert property (
        $fell(overlap_active) |-> ocnt_ff == 8'h04 + {2'b0, ov_lat_ff, 1'b0})
        else $error("overlap length wrong");
    chk_busy_len: assert property (
        $fell(swap_busy) |->
        bcnt_ff == 8'h05 + {2'b0, ov_lat_ff, 1'b0} + {3'b0, st_lat_ff})
        else $error("swap length wrong");
    chk_select_toggle: assert property (
        $fell(swap_busy) |-> $changed(steer_select))
        else $error("select not toggled at swap end");
    chk_select_quiet: assert property (
        $changed(steer_select) |-> $fell(swap_busy))
        else $error("select moved outside a swap");
    chk_start_take: assert property (
        swap_start && !swap_busy |=> swap_busy && overlap_active)
        else $error("swap not started");

    cover property (wb_err_o);
    cover property (wr_hit);
    cover property ($fell(swap_busy));
endmodule : core_swap_timing_trim_regs_chk

bind core_swap_timing_trim_regs core_swap_timing_trim_regs_chk
    core_swap_timing_trim_regs_chk_i (.clk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o,
    .swap_start, .overlap_active, .steer_select, .swap_busy);

// *** swap_sequencer.sv ***
`timescale 1ns/1ps
module swap_sequencer
    import swap_trim_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire logic      swap_start,
    input  wire swap_cfg_t cfg,
    output logic           overlap_active,
    output logic           steer_select,
    output logic           swap_busy,
    output logic           swap_done
);

    typedef enum logic [1:0] {IDLE, OVERLAP, STEER} seq_state_t;

    seq_state_t  state_ff;
    swap_cfg_t   cfg_ff;
    logic [6:0]  cnt_ff;
    logic        sel_ff;
    logic        done_ff;

    // ------------------------------------------------------------
    // Swap sequencing
    // ------------------------------------------------------------
    // Overlap: both cores sample for 4 + 2*overlap cycles, then the
    // steering select flips after the extra steer delay.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= IDLE;
            cfg_ff   <= '0;
            cnt_ff   <= '0;
            sel_ff   <= 1'b0;
            done_ff  <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            unique case (state_ff)
                IDLE:
                begin
                    if (swap_start)
                    begin
                        cfg_ff   <= cfg;                            // RQ11
                        cnt_ff   <= OVERLAP_BASE
                                    + {1'b0, cfg.overlap, 1'b0} - 7'h01; // RQ3
                        state_ff <= OVERLAP;
                    end
                end
                OVERLAP:
                begin
                    if (cnt_ff == 7'h00)
                    begin
                        cnt_ff   <= {2'h0, cfg_ff.steer};           // RQ6
                        state_ff <= STEER;
                    end
                    else
                        cnt_ff <= cnt_ff - 7'h01;
                end
                STEER:
                begin
                    if (cnt_ff == 7'h00)
                    begin
                        sel_ff   <= ~sel_ff;                        // RQ6
                        done_ff  <= 1'b1;
                        state_ff <= IDLE;
                    end
                    else
                        cnt_ff <= cnt_ff - 7'h01;
                end
            endcase
        end
    end

    assign overlap_active = (state_ff == OVERLAP);
    assign swap_busy      = (state_ff != IDLE);
    assign steer_select   = sel_ff;
    assign swap_done      = done_ff;

endmodule : swap_sequencer

// *** swap_trim_pkg.sv ***
package swap_trim_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // Printed offsets are not all multiples of four: they are word indices
    localparam logic [8:0]  IDX_TRIM_B        = 9'h07f;
    localparam logic [8:0]  IDX_TRIM_C        = 9'h080;
    localparam logic [8:0]  IDX_TRIM_D        = 9'h081;
    localparam logic [8:0]  IDX_OVERLAP       = 9'h09a;
    localparam logic [8:0]  IDX_STEER         = 9'h09b;
    localparam logic [8:0]  IDX_DITHER        = 9'h09d;
    localparam logic [8:0]  IDX_SWAP_STATUS   = 9'h0a0;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          DLY_W             = 5;
    localparam logic [4:0]  OVERLAP_RST       = 5'h08;
    localparam logic [4:0]  STEER_RST         = 5'h07;
    localparam logic [2:0]  DITHER_RST        = 3'h0;
    localparam int          DITH_EN_BIT       = 0;
    localparam int          DITH_AMP_BIT      = 1;
    localparam int          DITH_RND_BIT      = 2;
    localparam logic [6:0]  OVERLAP_BASE      = 7'h04;

    // Delay pair latched at swap start
    typedef struct packed {
        logic [4:0] overlap;
        logic [4:0] steer;
    } swap_cfg_t;

    typedef struct packed {
        logic       dither_enable;
        logic       dither_amplitude_select;
        logic       dither_rounding_choice;
    } dither_cfg_t;

endpackage : swap_trim_pkg
